// [rtl/bank_ptr_pkg.sv]
// Constants for bank and page pointer address generation
package bank_ptr_pkg;
  localparam int          BANK_MSB        = 15;
  localparam int          BANK_LSB        = 11;
  localparam int          PAGE_MSB        = 10;
  localparam int          PAGE_LSB        = 8;
  localparam logic [4:0]  BANK_RESET      = 5'h00;
  localparam logic [2:0]  PAGE_RESET      = 3'h0;
  localparam logic [7:0]  CCR_RESET       = 8'h30;
  localparam logic [7:0]  GREG_HIGH       = 8'h01;
  localparam logic [15:0] MIRROR_ADDR     = 16'h0078;
  localparam logic [15:0] HOLE_LO         = 16'h0080;
  localparam logic [15:0] HOLE_HI         = 16'h008f;
  // Direct addressing instruction classes
  typedef enum logic [3:0] {
    OP_CLRB  = 4'h0, OP_SETB = 4'h1, OP_BBC  = 4'h2, OP_BBS  = 4'h3,
    OP_MOVLD = 4'h4, OP_CMP  = 4'h5, OP_ADDC = 4'h6, OP_SUBC = 4'h7,
    OP_MOVST = 4'h8, OP_XOR  = 4'h9, OP_AND  = 4'ha, OP_OR   = 4'hb,
    OP_MOVIM = 4'hc, OP_CMPIM = 4'hd, OP_MOVWLD = 4'he, OP_MOVWST = 4'hf
  } dir_op_e;
endpackage

// [rtl/direct_page_map.sv]
// Paged direct operand translation
`timescale 1ns/1ps
module direct_page_map (
  input  wire logic [7:0]  operand,    // Direct operand byte
  input  wire logic [2:0]  page_sel,   // Page selector value
  output logic      [15:0] addr,       // Mapped address
  output logic             hole        // Operand falls in unreachable gap
);
  // Low half passes; upper half goes to window 0x80*(page+1)
  wire       upper = operand[7];
  wire [3:0] win   = {1'b0, page_sel} + 4'h1;
  assign addr = upper && (page_sel != 3'h0) ? {5'h00, win, operand[6:0]}
                                            : {8'h00, operand};
  assign hole = upper && (page_sel == 3'h0) && (operand[6:4] == 3'h0);
endmodule // direct_page_map

// [rtl/bank_pointer_address_gen.sv]
// Status word pointer fields and register or direct address generation
`timescale 1ns/1ps
module bank_pointer_address_gen (
  input  wire logic        mclk,          // Clock
  input  wire logic        rst_n,         // Synchronous reset, active low
  input  wire logic        psw_load,      // Status word load from accumulator
  input  wire logic [15:0] acc_word,      // Accumulator word
  input  wire logic        ccr_we,        // Condition code update by execute
  input  wire logic [7:0]  ccr_in,        // New condition codes
  input  wire logic        data_we,       // Data byte write
  input  wire logic        data_re,       // Data byte read
  input  wire logic [15:0] data_addr,     // Data byte address
  input  wire logic [7:0]  data_wdata,    // Data write byte
  input  wire logic        greg_req,      // Register address request
  input  wire logic [2:0]  opcode_low,    // Low three opcode bits
  input  wire logic        dir_req,       // Direct address request
  input  wire logic [3:0]  dir_op,        // Direct instruction class
  input  wire logic [7:0]  dir_operand,   // Direct operand byte
  output logic      [15:0] psw_q,         // Program status word
  output logic      [7:0]  mirror_rdata_q,// Mirror read data
  output logic             mirror_hit_q,  // Mirror read answered
  output logic      [15:0] greg_addr_q,   // Register area address
  output logic             greg_valid_q,  // Register address valid
  output logic      [15:0] dir_addr_q,    // Direct mapped address
  output logic             dir_valid_q,   // Direct address valid
  output logic             dir_fault_q    // Direct operand in gap, refused
);
  logic [4:0] bank_q;
  logic [2:0] page_q;
  logic [7:0] ccr_q;
  logic [15:0] map_addr;
  logic        map_hole;

  // Decode of mirror accesses and paged instruction classes
  wire mirror_wr = data_we && (data_addr == bank_ptr_pkg::MIRROR_ADDR);
  wire mirror_rd = data_re && (data_addr == bank_ptr_pkg::MIRROR_ADDR);
  wire paged_op  = (dir_op <= 4'(bank_ptr_pkg::OP_MOVWST));
  wire [15:0] psw_now = {bank_q, page_q, ccr_q};

  direct_page_map u_map (
    .operand  (dir_operand),
    .page_sel (page_q),
    .addr     (map_addr),
    .hole     (map_hole)
  );

  // Pointer fields; load wins over mirror write, condition codes untouched by mirror
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bank_q <= bank_ptr_pkg::BANK_RESET;
      page_q <= bank_ptr_pkg::PAGE_RESET;
    end else if (psw_load) begin
      bank_q <= acc_word[bank_ptr_pkg::BANK_MSB:bank_ptr_pkg::BANK_LSB];
      page_q <= acc_word[bank_ptr_pkg::PAGE_MSB:bank_ptr_pkg::PAGE_LSB];
    end else if (mirror_wr) begin
      bank_q <= data_wdata[7:3];
      page_q <= data_wdata[2:0];
    end
  end

  // Condition code byte
  always_ff @(posedge mclk) begin
    if (!rst_n) ccr_q <= bank_ptr_pkg::CCR_RESET;
    else if (psw_load) ccr_q <= acc_word[7:0];
    else if (ccr_we) ccr_q <= ccr_in;
  end

  // Registered outputs: status word, mirror read, register and direct addresses
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      psw_q          <= {bank_ptr_pkg::BANK_RESET, bank_ptr_pkg::PAGE_RESET, bank_ptr_pkg::CCR_RESET};
      mirror_rdata_q <= 8'h00;
      mirror_hit_q   <= 1'b0;
      greg_addr_q    <= 16'h0000;
      greg_valid_q   <= 1'b0;
      dir_addr_q     <= 16'h0000;
      dir_valid_q    <= 1'b0;
      dir_fault_q    <= 1'b0;
    end else begin
      psw_q          <= psw_now;
      mirror_rdata_q <= mirror_rd ? {bank_q, page_q} : 8'h00;
      mirror_hit_q   <= mirror_rd;
      greg_addr_q    <= {bank_ptr_pkg::GREG_HIGH, bank_q, opcode_low};
      greg_valid_q   <= greg_req;
      dir_addr_q     <= paged_op ? map_addr : {8'h00, dir_operand};
      dir_valid_q    <= dir_req && !(paged_op && map_hole);
      dir_fault_q    <= dir_req && paged_op && map_hole;
    end
  end

  // Checks: sequences for the single-cycle mirror write and for the behaviours that take more than one step
  sequence s_mirror_write;
    mirror_wr && !psw_load;
  endsequence

  // A load followed by one settling cycle before the status word output shows it
  sequence s_load_settle;
    psw_load ##1 1'b1;
  endsequence

  // Mirror write immediately followed by a register address request
  sequence s_mirror_then_greg;
    s_mirror_write ##1 greg_req;
  endsequence

  // Register area address form and range
  a_greg_range: assert property (@(posedge mclk) disable iff (!rst_n)
    greg_valid_q |-> greg_addr_q[15:8] == 8'h01)
    else $error("register address out of area");

  a_greg_form: assert property (@(posedge mclk) disable iff (!rst_n)
    greg_req |=> greg_addr_q[7:0] == {$past(bank_q), $past(opcode_low)})
    else $error("register address form");

  a_greg_bank: assert property (@(posedge mclk) disable iff (!rst_n)
    greg_req |=> greg_addr_q[7:3] == $past(bank_q))
    else $error("register bank bits wrong");

  a_greg_valid: assert property (@(posedge mclk) disable iff (!rst_n)
    greg_req |=> greg_valid_q && greg_addr_q[2:0] == $past(opcode_low))
    else $error("register select bits wrong");

  a_greg_once: assert property (@(posedge mclk) disable iff (!rst_n)
    !greg_req |=> !greg_valid_q)
    else $error("register valid without request");

  // Status word fields track the pointer registers one cycle later
  a_bank_field: assert property (@(posedge mclk) disable iff (!rst_n)
    psw_q[15:11] == $past(bank_q))
    else $error("bank field misplaced");

  a_page_field: assert property (@(posedge mclk) disable iff (!rst_n)
    psw_q[10:8] == $past(page_q))
    else $error("page field misplaced");

  // Mirror byte write and read
  a_mirror_upd: assert property (@(posedge mclk) disable iff (!rst_n)
    s_mirror_write |=> {bank_q, page_q} == $past(data_wdata))
    else $error("mirror write lost");

  a_mirror_read: assert property (@(posedge mclk) disable iff (!rst_n)
    mirror_rd |=> mirror_hit_q && mirror_rdata_q == {$past(bank_q), $past(page_q)})
    else $error("mirror read wrong");

  a_mirror_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    !mirror_rd |=> !mirror_hit_q && mirror_rdata_q == 8'h00)
    else $error("mirror answer without read");

  a_other_addr: assert property (@(posedge mclk) disable iff (!rst_n)
    data_we && (data_addr != bank_ptr_pkg::MIRROR_ADDR) && !psw_load |=> $stable({bank_q, page_q}))
    else $error("other address moved pointers");

  a_mirror_ccr: assert property (@(posedge mclk) disable iff (!rst_n)
    mirror_wr && !psw_load && !ccr_we |=> $stable(ccr_q))
    else $error("mirror write touched codes");

  a_next_instr: assert property (@(posedge mclk) disable iff (!rst_n)
    s_mirror_then_greg |=> greg_addr_q[7:3] == $past(data_wdata[7:3], 2))
    else $error("new bank not used next");

  // Status word load from the accumulator
  a_load_fields: assert property (@(posedge mclk) disable iff (!rst_n)
    s_load_settle |=> psw_q == $past(acc_word, 2))
    else $error("status word load wrong");

  a_load_bank: assert property (@(posedge mclk) disable iff (!rst_n)
    psw_load |=> bank_q == $past(acc_word[15:11]) && page_q == $past(acc_word[10:8]))
    else $error("load missed a selector");

  a_load_wins: assert property (@(posedge mclk) disable iff (!rst_n)
    psw_load && mirror_wr |=> {bank_q, page_q} == $past(acc_word[15:8]))
    else $error("mirror beat a load");

  a_ccr_load: assert property (@(posedge mclk) disable iff (!rst_n)
    psw_load |=> ccr_q == $past(acc_word[7:0]))
    else $error("load missed condition codes");

  // Direct operand mapping
  a_low_direct: assert property (@(posedge mclk) disable iff (!rst_n)
    dir_req && !dir_operand[7] |=> dir_valid_q && dir_addr_q == {8'h00, $past(dir_operand)})
    else $error("low operand remapped");

  a_no_hole: assert property (@(posedge mclk) disable iff (!rst_n)
    dir_valid_q |-> !(dir_addr_q >= bank_ptr_pkg::HOLE_LO && dir_addr_q <= bank_ptr_pkg::HOLE_HI))
    else $error("gap address produced");

  a_fault_hole: assert property (@(posedge mclk) disable iff (!rst_n)
    dir_req && dir_operand[7:4] == 4'h8 && page_q == 3'h0 |=> dir_fault_q && !dir_valid_q)
    else $error("gap operand not refused");

  a_dir_range: assert property (@(posedge mclk) disable iff (!rst_n)
    dir_valid_q |-> dir_addr_q <= 16'h047f)
    else $error("direct address beyond reach");

  a_dir_excl: assert property (@(posedge mclk) disable iff (!rst_n)
    !(dir_valid_q && dir_fault_q))
    else $error("direct valid and fault together");

  a_page_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    dir_req && dir_operand >= 8'h90 && page_q == 3'h0 |=> dir_valid_q && dir_addr_q == {8'h00, $past(dir_operand)})
    else $error("page zero operand moved");

  a_page_base: assert property (@(posedge mclk) disable iff (!rst_n)
    dir_req && dir_operand[7] && page_q != 3'h0
    |=> dir_addr_q == {5'h00, {1'b0, $past(page_q)} + 4'h1, $past(dir_operand[6:0])})
    else $error("page window base wrong");

  a_page_window: assert property (@(posedge mclk) disable iff (!rst_n)
    dir_req && dir_operand[7] && page_q == 3'h7 |=> dir_addr_q[15:7] == 9'h008)
    else $error("page seven window wrong");

  a_dir_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    !dir_req |=> !dir_valid_q && !dir_fault_q)
    else $error("direct answer without request");

  // Reset values of the selectors
  a_reset_bank: assert property (@(posedge mclk)
    !rst_n |=> bank_q == 5'h00 && psw_q[15:11] == 5'h00)
    else $error("bank not cleared");

  a_reset_page: assert property (@(posedge mclk)
    !rst_n |=> page_q == 3'h0)
    else $error("page not cleared");
endmodule // bank_pointer_address_gen

// [bench/mirror_access_model.sv]
// Execute-side stand-in that issues data byte accesses
`timescale 1ns/1ps
module mirror_access_model (
  input  wire logic        mclk,      // Clock
  input  wire logic        kick_we,   // Issue a byte write
  input  wire logic        kick_re,   // Issue a byte read
  input  wire logic [15:0] kick_addr, // Byte address to use
  input  wire logic [7:0]  kick_byte, // Byte to write
  output logic             data_we,   // Write strobe
  output logic             data_re,   // Read strobe
  output logic      [15:0] data_addr, // Byte address
  output logic      [7:0]  data_wdata // Write byte
);
  // Strobes follow the kicks one cycle later; an idle bus shows inverted values so stale data is never seen
  always_ff @(posedge mclk) begin
    data_we    <= kick_we;
    data_re    <= kick_re;
    data_addr  <= (kick_we | kick_re) ? kick_addr : ~kick_addr;
    data_wdata <= kick_we ? kick_byte : ~kick_byte;
  end
endmodule // mirror_access_model

// [bench/bank_pointer_address_gen_tb_top.sv]
// Self-checking bench for bank and page pointer address generation
`timescale 1ns/1ps
module bank_pointer_address_gen_tb_top;
  logic        mclk, rst_n, psw_load, greg_req, dir_req, kick_we, kick_re, data_we, data_re, mirror_hit_q;
  logic        greg_valid_q, dir_valid_q, dir_fault_q;
  logic [15:0] acc_word, kick_addr, data_addr, psw_q, greg_addr_q, dir_addr_q, w;
  logic [7:0]  kick_byte, dir_operand, data_wdata, mirror_rdata_q, b;
  logic [3:0]  dir_op;
  logic [2:0]  opcode_low;
  logic [16:0] e;
  int          err_total = 0;
  int          tests_run = 0;
  bank_pointer_address_gen DUT (.mclk(mclk), .rst_n(rst_n), .psw_load(psw_load), .acc_word(acc_word),
    .ccr_we(1'b0), .ccr_in(8'h00), .data_we(data_we), .data_re(data_re), .data_addr(data_addr),
    .data_wdata(data_wdata), .greg_req(greg_req), .opcode_low(opcode_low), .dir_req(dir_req), .dir_op(dir_op),
    .dir_operand(dir_operand), .psw_q(psw_q), .mirror_rdata_q(mirror_rdata_q), .mirror_hit_q(mirror_hit_q),
    .greg_addr_q(greg_addr_q), .greg_valid_q(greg_valid_q), .dir_addr_q(dir_addr_q),
    .dir_valid_q(dir_valid_q), .dir_fault_q(dir_fault_q));
  mirror_access_model cpu (.mclk(mclk), .kick_we(kick_we), .kick_re(kick_re), .kick_addr(kick_addr),
    .kick_byte(kick_byte), .data_we(data_we), .data_re(data_re), .data_addr(data_addr), .data_wdata(data_wdata));
  // Clock at 5 ns period
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [16:0] x, input logic [16:0] s);
    tests_run++;
    if (x !== s) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic give_verdict;
    $display("mismatches %0d, checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Expected {fault, address} of a direct operand under a page selector
  function automatic logic [16:0] exp_dir(input logic [7:0] o, input logic [2:0] p);
    if (o < 8'h80 || (p == 3'h0 && o > 8'h8f)) return {9'h000, o};
    if (p == 3'h0) return {1'b1, 16'h0000};
    return {6'h00, 4'(p) + 4'h1, o[6:0]};
  endfunction
  // Hang guard
  initial begin
    #20000;
    err_total++;
    give_verdict();
  end
  // Main sequence: load, address requests, mirror write then read
  initial begin
    void'($urandom(81432));
    {rst_n, psw_load, greg_req, dir_req, kick_we, kick_re} = '0;
    {acc_word, kick_addr, kick_byte, dir_operand, dir_op, opcode_low} = '0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1 chk("reset status word", 17'h00030, {1'b0, psw_q});
    for (int i = 0; i < 64; i++) begin
      w = (i == 0) ? 16'hff5a : 16'($urandom);
      b = 8'($urandom);
      @(posedge mclk);
      psw_load <= 1'b1;
      acc_word <= w;
      @(posedge mclk);
      psw_load <= 1'b0;
      {greg_req, dir_req} <= 2'b11;
      opcode_low <= 3'($urandom);
      dir_op <= 4'(i);
      dir_operand <= (i % 3 == 0) ? 8'h80 + 8'(i % 17) : 8'($urandom);
      @(posedge mclk);
      {greg_req, dir_req, kick_we} <= 3'b001;
      kick_addr <= (i % 4 == 3) ? 16'h0079 : 16'h0078;
      kick_byte <= b;
      #1 e = exp_dir(dir_operand, w[10:8]);
      chk("status word", {1'b0, w}, {1'b0, psw_q});
      chk("register address", {1'b1, 8'h01, w[15:11], opcode_low}, {greg_valid_q, greg_addr_q});
      chk("direct fault", {15'h0000, e[16], !e[16]}, {15'h0000, dir_fault_q, dir_valid_q});
      if (!e[16]) chk("direct address", e, {1'b0, dir_addr_q});
      @(posedge mclk);
      {kick_we, kick_re} <= 2'b01;
      if (kick_addr != 16'h0078) b = w[15:8];
      @(posedge mclk);
      {kick_re, greg_req} <= 2'b01;
      @(posedge mclk);
      greg_req <= 1'b0;
      #1 chk("status after mirror", {1'b0, b, w[7:0]}, {1'b0, psw_q});
      chk("register after mirror", {1'b1, 8'h01, b[7:3], opcode_low}, {greg_valid_q, greg_addr_q});
      chk("mirror read", (kick_addr == 16'h0078) ? {9'h100, b} : 17'h0, {mirror_hit_q, 8'h00, mirror_rdata_q});
    end
    give_verdict();
  end
endmodule // bank_pointer_address_gen_tb_top
